// ---- hw/unsigned_sat_narrow_unit.sv ----
/*
 * Unsigned saturating narrowing unit: reads two or four aligned
 * source vectors, optionally rounds and shifts, saturates, writes one
 * destination vector. Assumes the register file returns read data
 * combinationally while rd_en is high, and that decode holds a request
 * until it is taken.
 */
`timescale 1ns/100ps
`default_nettype none

module unsigned_sat_narrow_unit
    import narrow_pkg::*;
(
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst,
    input  wire logic                                   feature_present,
    input  wire logic                                   streaming_enabled,
    input  wire logic                                   req_valid,
    input  wire narrow_pkg::op_t                        req_op,
    input  wire logic                                   element_size_bit,
    input  wire logic [1:0]                             type_size_field,
    input  wire logic [3:0]                             shift_immediate_short,
    input  wire logic [4:0]                             shift_immediate_wide,
    input  wire logic [3:0]                             source_group_field,
    input  wire logic [narrow_pkg::REG_IDX_W-1:0]       destination_vector_field,
    input  wire logic [3:0][narrow_pkg::VEC_BITS-1:0]   rd_data,
    output logic                                        req_ready,
    output logic                                        rd_en,
    output logic [3:0][narrow_pkg::REG_IDX_W-1:0]       rd_index,
    output logic                                        wr_en,
    output logic [narrow_pkg::REG_IDX_W-1:0]            wr_index,
    output logic [narrow_pkg::VEC_BITS-1:0]             wr_data,
    output logic                                        undef_pulse,
    output logic                                        trap_pulse
);
    import narrow_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Decode helpers

    // Four-source group operations
    function automatic logic is_quad(input op_t op);
        return (op == EXTRACT_NARROW_QUAD_OP) || (op == EXTRACT_NARROW_INTERLEAVE_OP) ||
               (op == ROUND_SHIFT_NARROW_QUAD_OP) ||
               (op == ROUND_SHIFT_NARROW_INTERLEAVE_OP);
    endfunction : is_quad

    // Operations that shift, any group size
    function automatic logic is_shift(input op_t op);
        return (op == ROUND_SHIFT_NARROW_PAIR_OP) || (op == ROUND_SHIFT_NARROW_QUAD_OP) ||
               (op == ROUND_SHIFT_NARROW_INTERLEAVE_OP);
    endfunction : is_shift

    // Round, shift and clamp one element; zero shift means plain extract
    function automatic logic [15:0] narrow_elem(input logic [63:0] val,
                                                input logic [SHIFT_W-1:0] sh,
                                                input logic d16);
        logic [64:0] rnd;
        logic [64:0] sum;
        logic [15:0] lim;
        rnd = (sh == NO_SHIFT) ? 65'h0 : (65'h1 << (sh - ONE_SHIFT));
        sum = ({1'b0, val} + rnd) >> sh;
        lim = d16 ? MAX_HALF : MAX_BYTE;
        return (sum > {49'h0, lim}) ? lim : sum[15:0];
    endfunction : narrow_elem

    ////////////////////////////////////////////////////////////////////
    // Request decode, combinational

    logic                 take;       // Request accepted this cycle
    logic                 dec_quad;   // Four sources
    logic                 dec_d16;    // Halfword results
    logic                 dec_ilv;    // Interleaved placement
    logic                 dec_undef;  // Undefined encoding
    logic [SHIFT_W-1:0]   dec_shift;  // Right shift amount

    assign take = req_valid && req_ready;

    // Size, shift and legality of the incoming request
    always_comb begin
        dec_quad  = is_quad(req_op);
        dec_ilv   = (req_op == EXTRACT_NARROW_INTERLEAVE_OP) ||
                    (req_op == ROUND_SHIFT_NARROW_INTERLEAVE_OP);
        dec_shift = NO_SHIFT;
        dec_d16   = 1'b1;
        dec_undef = !feature_present;
        case (req_op)
            EXTRACT_NARROW_PAIR_OP: begin
                dec_d16 = 1'b1;
            end
            EXTRACT_NARROW_QUAD_OP, EXTRACT_NARROW_INTERLEAVE_OP: begin
                // Width is a byte shifted by the size bit
                dec_d16 = element_size_bit;
            end
            ROUND_SHIFT_NARROW_PAIR_OP: begin
                dec_shift = PAIR_ESIZE - {4'h0, shift_immediate_short};
            end
            ROUND_SHIFT_NARROW_QUAD_OP, ROUND_SHIFT_NARROW_INTERLEAVE_OP: begin
                dec_d16   = type_size_field[1];
                // Stays in the 1..source-width range by construction, no wrap
                dec_shift = (type_size_field[1] ? QUAD_BASE_H : QUAD_BASE_B)
                            - {1'b0, type_size_field, shift_immediate_wide};
                if (type_size_field == TSIZE_UNDEF) begin
                    dec_undef = 1'b1;
                end
            end
            default: begin
                dec_undef = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Latched operation fields

    logic                 quad_ff;   // Four sources
    logic                 d16_ff;    // Halfword results
    logic                 ilv_ff;    // Interleaved placement
    logic [SHIFT_W-1:0]   shift_ff;  // Shift amount
    op_t                  op_ff;     // Operation in flight

    // Capture on acceptance only
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            quad_ff  <= 1'b0;
            d16_ff   <= 1'b0;
            ilv_ff   <= 1'b0;
            shift_ff <= NO_SHIFT;
            op_ff    <= EXTRACT_NARROW_PAIR_OP;
        end else if (take) begin
            quad_ff  <= dec_quad;
            d16_ff   <= dec_d16;
            ilv_ff   <= dec_ilv;
            shift_ff <= dec_shift;
            op_ff    <= req_op;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer: idle, read sources, write result

    state_t state_ff;   // Current state
    state_t nxt_state;  // Next state

    // Undefined and trapped requests never leave idle
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (take && !dec_undef && streaming_enabled) begin
                    nxt_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                nxt_state = ST_WRITE;
            end
            ST_WRITE: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Ready only while idle; one request in flight at a time
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (nxt_state == ST_IDLE);
        end
    end

    // Exception pulses; undefined outranks the streaming trap
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            undef_pulse <= 1'b0;
            trap_pulse  <= 1'b0;
        end else begin
            undef_pulse <= take && dec_undef;
            trap_pulse  <= take && !dec_undef && !streaming_enabled;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Source register reads

    // Read indices: aligned group base plus offset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rd_en    <= 1'b0;
            rd_index <= '0;
        end else begin
            rd_en <= (nxt_state == ST_FETCH);
            if (take) begin
                for (int r = 0; r < NUM_SRC; r++) begin
                    if (dec_quad) begin
                        rd_index[r] <= {source_group_field[2:0], 2'b00}
                                       + REG_IDX_W'(r);
                    end else begin
                        rd_index[r] <= {source_group_field, 1'b0}
                                       + REG_IDX_W'(r & 1);
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Narrowing datapath, no predicate anywhere

    logic [VEC_BITS-1:0] result;  // Assembled destination vector

    // Every lane of every source goes through the same narrowing path
    always_comb begin
        int epr;
        int pos;
        logic [63:0] val;
        logic [15:0] nv;
        epr    = (quad_ff && d16_ff) ? EPR_DWORD : EPR_WORD;
        pos    = 0;
        val    = '0;
        nv     = '0;
        result = '0;
        for (int r = 0; r < NUM_SRC; r++) begin
            for (int e = 0; e < EPR_WORD; e++) begin
                if ((quad_ff || r < 2) && e < epr) begin
                    if (quad_ff && d16_ff) begin
                        val = rd_data[r][e*DWORD_W +: DWORD_W];
                    end else begin
                        val = {32'h0, rd_data[r][e*WORD_W +: WORD_W]};
                    end
                    nv  = narrow_elem(val, shift_ff, d16_ff);
                    // Interleave by element, or slice by source
                    pos = ilv_ff ? (4 * e + r) : (r * epr + e);
                    if (d16_ff) begin
                        result[pos*HALF_W +: HALF_W] = nv;
                    end else begin
                        result[pos*BYTE_W +: BYTE_W] = nv[7:0];
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Destination write

    // Result registered on the fetch cycle's edge, index on acceptance
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_en    <= 1'b0;
            wr_index <= '0;
            wr_data  <= '0;
        end else begin
            wr_en <= (state_ff == ST_FETCH);
            if (take) begin
                wr_index <= destination_vector_field;
            end
            if (state_ff == ST_FETCH) begin
                wr_data <= result;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks

    chk_undef_feature: assert property (@(posedge sys_clk) disable iff (rst)
        take && !feature_present |=> undef_pulse && !rd_en ##1 !wr_en)
        else $error("missing feature did not give undefined");

    chk_trap_stream: assert property (@(posedge sys_clk) disable iff (rst)
        take && !dec_undef && !streaming_enabled |=> trap_pulse && !rd_en ##1 !wr_en)
        else $error("streaming off did not trap cleanly");

    chk_tsize_undef: assert property (@(posedge sys_clk) disable iff (rst)
        take && feature_present && is_shift(req_op) && is_quad(req_op)
        && type_size_field == TSIZE_UNDEF |=> undef_pulse && !trap_pulse)
        else $error("reserved type-size not undefined");

    chk_pair_index: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && !quad_ff |-> rd_index[0][0] == 1'b0
        && rd_index[1] == rd_index[0] + 5'h01)
        else $error("pair source indices wrong");

    chk_quad_index: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && quad_ff |-> rd_index[0][1:0] == 2'b00
        && rd_index[3] == rd_index[0] + 5'h03)
        else $error("quad source indices wrong");

    chk_pair_shift: assert property (@(posedge sys_clk) disable iff (rst)
        take && req_op == ROUND_SHIFT_NARROW_PAIR_OP |=>
        shift_ff == PAIR_ESIZE - {4'h0, $past(shift_immediate_short)}
        && shift_ff >= ONE_SHIFT && shift_ff <= PAIR_ESIZE)
        else $error("pair shift out of range");

    chk_quad_shift: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && is_shift(op_ff) && quad_ff |->
        shift_ff >= ONE_SHIFT && shift_ff <= (d16_ff ? 8'h40 : 8'h20))
        else $error("quad shift out of range");

    chk_sat_clamp: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && op_ff == EXTRACT_NARROW_PAIR_OP && rd_data[0][31:0] > 32'h0000FFFF
        |=> wr_en && wr_data[15:0] == MAX_HALF)
        else $error("saturation did not clamp");

    chk_round_add: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && op_ff == ROUND_SHIFT_NARROW_PAIR_OP && shift_ff == ONE_SHIFT
        && rd_data[0][31:0] == 32'h00000003 |=> wr_data[15:0] == 16'h0002)
        else $error("rounding constant not applied");

    chk_ilv_place: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && op_ff == EXTRACT_NARROW_INTERLEAVE_OP && !d16_ff
        && rd_data[1][31:0] < 32'h00000100
        |=> wr_data[15:8] == $past(rd_data[1][7:0]))
        else $error("interleaved placement wrong");

    chk_slice_place: assert property (@(posedge sys_clk) disable iff (rst)
        rd_en && op_ff == EXTRACT_NARROW_QUAD_OP && !d16_ff
        && rd_data[1][31:0] < 32'h00000100
        |=> wr_data[39:32] == $past(rd_data[1][7:0]))
        else $error("sliced placement wrong");

endmodule : unsigned_sat_narrow_unit

`default_nettype wire

// ---- hw/narrow_pkg.sv ----
/*
 * Constants, encodings and state codes for the unsigned saturating
 * narrowing datapath. Assumes a fixed vector length and a register
 * file that answers reads in the same cycle the read is requested.
 */
// Functional notes
// - Interleaved extract puts element e, source i at 4e+i
// - Pair shift: 16-bit results, shift sixteen minus immediate
// - Add half-step rounding constant, then shift right
// - Clamp each result to unsigned destination maximum
// - Non-interleaved results sit in per-source contiguous slices
// - Pair sources start at twice the group field
// - Quad sources start at four times group field
// - Type-size 00 undefined, 01 bytes, 1x halfwords
// - Quad shift is eight times width minus immediate
// - Every element processed, no predicate mask
// - Quad per-source count is length over four widths
// - Pair per-source count is length over two widths
// - Interleaved shift rounds, saturates, then interleaves streams
// - Everything undefined without the matrix feature present
// - Interleaved extract size bit: 0 bytes, 1 halfwords
// - Extract destination width is eight shifted by size
package narrow_pkg;

    // Vector length in bits, fixed for this implementation
    localparam int unsigned VEC_BITS     = 128;
    localparam int unsigned NUM_SRC      = 4;
    localparam int unsigned REG_IDX_W    = 5;
    localparam int unsigned SHIFT_W      = 8;
    // Element widths
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned HALF_W       = 16;
    localparam int unsigned WORD_W       = 32;
    localparam int unsigned DWORD_W      = 64;
    // Shift arithmetic
    localparam logic [SHIFT_W-1:0] PAIR_ESIZE   = 8'h10;  // Sixteen bit results
    localparam logic [SHIFT_W-1:0] QUAD_BASE_B  = 8'h40;  // Eight times byte width
    localparam logic [SHIFT_W-1:0] QUAD_BASE_H  = 8'h80;  // Eight times halfword width
    localparam logic [SHIFT_W-1:0] NO_SHIFT     = 8'h00;
    localparam logic [SHIFT_W-1:0] ONE_SHIFT    = 8'h01;
    // Saturation limits
    localparam logic [15:0] MAX_HALF     = 16'hFFFF;
    localparam logic [15:0] MAX_BYTE     = 16'h00FF;
    // Type-size codes
    localparam logic [1:0]  TSIZE_UNDEF  = 2'b00;
    // Per-source element counts for 32- and 64-bit sources
    localparam int unsigned EPR_WORD     = VEC_BITS / (2 * HALF_W);
    localparam int unsigned EPR_DWORD    = VEC_BITS / (4 * HALF_W);

    // Operation select from decode
    typedef enum logic [2:0] {
        EXTRACT_NARROW_PAIR_OP          = 3'b000,
        EXTRACT_NARROW_QUAD_OP          = 3'b001,
        EXTRACT_NARROW_INTERLEAVE_OP    = 3'b010,
        ROUND_SHIFT_NARROW_PAIR_OP      = 3'b011,
        ROUND_SHIFT_NARROW_QUAD_OP      = 3'b100,
        ROUND_SHIFT_NARROW_INTERLEAVE_OP = 3'b101,
        RESERVED_A_OP                   = 3'b110,
        RESERVED_B_OP                   = 3'b111
    } op_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_WRITE = 2'b10
    } state_t;

endpackage : narrow_pkg

// ---- tb/vreg_file_model.sv ----
/*
 * Behavioural vector register file facing the narrowing unit.
 * Assumes the unit reads with rd_en/rd_index and writes with wr_en.
 */
`timescale 1ns/100ps
`default_nettype none

module vreg_file_model
    import narrow_pkg::*;
(
    input  wire logic                      sys_clk,
    input  wire logic                      rd_en,
    input  wire logic [3:0][narrow_pkg::REG_IDX_W-1:0] rd_index,
    input  wire logic                                  wr_en,
    input  wire logic [narrow_pkg::REG_IDX_W-1:0]      wr_index,
    input  wire logic [narrow_pkg::VEC_BITS-1:0]       wr_data,
    output logic [3:0][narrow_pkg::VEC_BITS-1:0]       rd_data
);
    import narrow_pkg::*;

    logic [VEC_BITS-1:0] mem [32];          // Register contents, preloaded by bench
    logic [VEC_BITS-1:0] noise_ff = '0;     // Changes every cycle outside reads

    ////////////////////////////////////////////////////////////////////////
    // Write port and idle noise; noise keeps stale data from looking valid
    always @(posedge sys_clk) begin
        noise_ff <= {noise_ff[VEC_BITS-2:0], ~noise_ff[VEC_BITS-1]};
        if (wr_en) begin
            mem[wr_index] <= wr_data;
        end
    end

    // Read port answers in the same cycle as rd_en
    always_comb begin
        for (int r = 0; r < 4; r++) begin
            rd_data[r] = rd_en ? mem[rd_index[r]] : noise_ff;
        end
    end
endmodule : vreg_file_model

`default_nettype wire

// ---- tb/unsigned_sat_narrow_unit_tb_top.sv ----
/*
 * Self-checking bench for the narrowing unit: every op and size, refusal
 * paths and a reset in mid-operation. Assumes the register file model.
 */
`timescale 1ns/100ps
`default_nettype none

module unsigned_sat_narrow_unit_tb_top;
    import narrow_pkg::*;

    logic                      sys_clk = 1'b0;
    logic                      rst;
    logic                      feat, strm, req_valid, esb;
    op_t                       req_op;
    logic [1:0]                tsz;
    logic [3:0]                imm_s, grp;
    logic [4:0]                imm_w, dst;
    logic [3:0][VEC_BITS-1:0]  rd_data;
    logic                      req_ready, rd_en, wr_en, undef_pulse, trap_pulse;
    logic [3:0][REG_IDX_W-1:0] rd_index;
    logic [REG_IDX_W-1:0]      wr_index;
    logic [VEC_BITS-1:0]       wr_data;
    int                        err_count = 0;
    int                        compares = 0;

    always #5 sys_clk = ~sys_clk;

    unsigned_sat_narrow_unit u_unsigned_sat_narrow_unit (
        .sys_clk(sys_clk), .rst(rst), .feature_present(feat), .streaming_enabled(strm),
        .req_valid(req_valid), .req_op(req_op), .element_size_bit(esb),
        .type_size_field(tsz), .shift_immediate_short(imm_s), .shift_immediate_wide(imm_w),
        .source_group_field(grp), .destination_vector_field(dst), .rd_data(rd_data),
        .req_ready(req_ready), .rd_en(rd_en), .rd_index(rd_index), .wr_en(wr_en),
        .wr_index(wr_index), .wr_data(wr_data), .undef_pulse(undef_pulse),
        .trap_pulse(trap_pulse));

    vreg_file_model u_vreg_file_model (
        .sys_clk(sys_clk), .rd_en(rd_en), .rd_index(rd_index), .wr_en(wr_en),
        .wr_index(wr_index), .wr_data(wr_data), .rd_data(rd_data));

    ////////////////////////////////////////////////////////////////////////
    // Reporting
    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    task automatic cmp(input logic [VEC_BITS-1:0] got, input logic [VEC_BITS-1:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    ////////////////////////////////////////////////////////////////////////
    // Reference result, worked out element by element
    function automatic logic [VEC_BITS-1:0] exp_calc(op_t op, logic [3:0][VEC_BITS-1:0] src);
        int nsrc, dw, shift, epr, pos;
        logic [VEC_BITS-1:0] el, res, mx;
        bit ilv;
        exp_calc = '0;
        nsrc = 4;
        dw = 8 << esb;
        shift = 0;
        ilv = (op == EXTRACT_NARROW_INTERLEAVE_OP);
        case (op)
            EXTRACT_NARROW_PAIR_OP: begin
                nsrc = 2;
                dw = 16;
            end
            ROUND_SHIFT_NARROW_PAIR_OP: begin
                nsrc = 2;
                dw = 16;
                shift = 16 - imm_s;
            end
            ROUND_SHIFT_NARROW_QUAD_OP, ROUND_SHIFT_NARROW_INTERLEAVE_OP: begin
                dw = tsz[1] ? 16 : 8;
                shift = 8 * dw - {tsz, imm_w};
                ilv = (op == ROUND_SHIFT_NARROW_INTERLEAVE_OP);
            end
            default: begin
                nsrc = 4;
            end
        endcase
        epr = VEC_BITS / (nsrc * dw);
        mx = (128'h1 << dw) - 1;
        for (int r = 0; r < nsrc; r++) begin
            for (int e = 0; e < epr; e++) begin
                el = (src[r] >> (e * nsrc * dw)) & ((128'h1 << (nsrc * dw)) - 1);
                res = (shift > 0) ? (el + (128'h1 << (shift - 1))) >> shift : el;
                if (res > mx) res = mx;
                pos = ilv ? 4 * e + r : r * epr + e;
                exp_calc = exp_calc | (res << (pos * dw));
            end
        end
    endfunction : exp_calc

    ////////////////////////////////////////////////////////////////////////
    // One request: kind 0 normal, 1 undefined, 2 trap. Entered at a falling edge.
    task automatic do_op(op_t op, int kind);
        logic [3:0][VEC_BITS-1:0] src;
        logic [4:0] base;
        bit pair;
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, req_ready, 1'b1);
            wrap_up();
        end
        req_op = op;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        pair = (op == EXTRACT_NARROW_PAIR_OP || op == ROUND_SHIFT_NARROW_PAIR_OP);
        base = pair ? {grp, 1'b0} : {grp[2:0], 2'b00};
        for (int r = 0; r < 4; r++) begin
            src[r] = u_vreg_file_model.mem[base + (pair ? r % 2 : r)];
        end
        cmp(rd_en, kind == 0);
        cmp(undef_pulse, kind == 1);
        cmp(trap_pulse, kind == 2);
        if (kind == 0) begin
            cmp(rd_index[0], base);
            cmp(rd_index[1], base + 5'h01);
            if (!pair) cmp(rd_index[3], base + 5'h03);
        end
        @(negedge sys_clk);
        cmp(wr_en, kind == 0);
        if (kind == 0) begin
            cmp(wr_index, dst);
            cmp(wr_data, exp_calc(op, src));
        end
    endtask : do_op

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sc_extract();
        grp = 4'h3;
        do_op(EXTRACT_NARROW_PAIR_OP, 0);
        for (int s = 0; s < 2; s++) begin
            esb = s[0];
            do_op(EXTRACT_NARROW_QUAD_OP, 0);
            do_op(EXTRACT_NARROW_INTERLEAVE_OP, 0);
        end
    endtask : sc_extract

    task automatic sc_shift_pair();
        grp = 4'hE;
        imm_s = 4'h0;
        do_op(ROUND_SHIFT_NARROW_PAIR_OP, 0);
        imm_s = 4'hF;
        do_op(ROUND_SHIFT_NARROW_PAIR_OP, 0);
        imm_s = 4'h7;
        do_op(ROUND_SHIFT_NARROW_PAIR_OP, 0);
    endtask : sc_shift_pair

    task automatic sc_shift_quad();
        grp = 4'h5;
        for (int t = 1; t < 4; t++) begin
            tsz = t[1:0];
            imm_w = (t == 2) ? 5'h00 : 5'h1F;
            do_op(ROUND_SHIFT_NARROW_QUAD_OP, 0);
            imm_w = 5'h0B;
            do_op(ROUND_SHIFT_NARROW_INTERLEAVE_OP, 0);
        end
    endtask : sc_shift_quad

    task automatic sc_refused();
        tsz = 2'b00;
        do_op(ROUND_SHIFT_NARROW_QUAD_OP, 1);
        do_op(ROUND_SHIFT_NARROW_INTERLEAVE_OP, 1);
        do_op(RESERVED_A_OP, 1);
        do_op(RESERVED_B_OP, 1);
        tsz = 2'b01;
        strm = 1'b0;
        do_op(ROUND_SHIFT_NARROW_PAIR_OP, 2);
        feat = 1'b0;
        do_op(EXTRACT_NARROW_QUAD_OP, 1);
        strm = 1'b1;
        do_op(EXTRACT_NARROW_PAIR_OP, 1);
        feat = 1'b1;
    endtask : sc_refused

    // Reset during the read cycle must swallow the write
    task automatic sc_reset_midop();
        req_op = EXTRACT_NARROW_PAIR_OP;
        req_valid = 1'b1;
        @(negedge sys_clk);
        req_valid = 1'b0;
        rst = 1'b1;
        @(negedge sys_clk);
        cmp(wr_en, 1'b0);
        cmp(req_ready, 1'b0);
        rst = 1'b0;
        @(negedge sys_clk);
        do_op(EXTRACT_NARROW_QUAD_OP, 0);
    endtask : sc_reset_midop

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: mixed patterns give both saturating and small elements
    initial begin
        for (int i = 0; i < 32; i++) begin
            u_vreg_file_model.mem[i] = {32'h0000_7F80 + 32'(i), 32'hFFFF_FFF0 - 32'(i),
                                        32'h0000_00FF, 32'(i) << 9};
        end
        // Lanes that wake the clamp, rounding and placement checks
        u_vreg_file_model.mem[6][31:0]  = 32'h0001_2345;  // Pair extract saturates lane 0
        u_vreg_file_model.mem[13][31:0] = 32'h0000_005A;  // Small lane for placement checks
        u_vreg_file_model.mem[28][31:0] = 32'h0000_0003;  // Rounds up under shift of one
        rst = 1'b1;
        {feat, strm} = 2'b11;
        {req_valid, esb, tsz, imm_s, imm_w, grp} = '0;
        req_op = EXTRACT_NARROW_PAIR_OP;
        dst = 5'h1F;
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        cmp(req_ready, 1'b0);
        cmp(wr_en, 1'b0);
        rst = 1'b0;
        @(negedge sys_clk);
        sc_extract();
        sc_shift_pair();
        sc_shift_quad();
        sc_refused();
        sc_reset_midop();
        wrap_up();
    end
endmodule : unsigned_sat_narrow_unit_tb_top

`default_nettype wire
